/* File: hdl/piu_interrupt_unit.sv */
// Peripheral interrupt unit: request flags, enables, priority vectoring and wake-up
//
// Functional notes
// - Each timer comparator has own flag, enable
// - Vector needs global, source enable, flag, stack
// - Timer service clears its flag and global
// - Write-complete sets flag, gated by enables
// - Write-complete service clears flag and global
// - Low supply sets flag, gated by enables
// - Low supply service clears flag and global
// - Touch slot overflow sets flag, gated
// - Touch service clears flag and global
// - Serial byte, address, timeout set flag
// - Serial service clears flag and global
// - Six async conditions form active-low request
// - Async service leaves port status untouched
// - Any flag rising wakes, enables ignored
// - Flags stay set until serviced or cleared
// - Return-from-irq sets global; plain return not
// - Each source has distinct vector address
// - Full stack blocks acknowledges from the next cycle on
// - Requests latch while global enable cleared
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "piu_consts.svh"

module piu_interrupt_unit
  import piu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [`PIU_ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire piu_events_t i_events,
  input wire logic i_low_supply,
  input wire logic i_stack_full,
  input wire logic i_vec_take,
  input wire logic i_return_from_irq_instr,
  output piu_vec_t o_vec,
  output logic o_wake,
  output logic o_global_irq_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Lowest set bit wins, giving a fixed priority order
  function automatic logic [`PIU_IDX_W-1:0] first_set(input piu_src_vec_t v);
    logic [`PIU_IDX_W-1:0] idx;
    idx = '0;
    for (int i = `PIU_NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = i[`PIU_IDX_W-1:0];
      end
    end
    return idx;
  endfunction

  // One-hot mask for a source index
  function automatic piu_src_vec_t src_mask(input logic [`PIU_IDX_W-1:0] idx);
    piu_src_vec_t m;
    m = '0;
    m[idx] = 1'b1;
    return m;
  endfunction

  // Vector address of a source
  function automatic logic [`PIU_VEC_W-1:0] vec_addr(input logic [`PIU_IDX_W-1:0] idx);
    logic [`PIU_VEC_W-1:0] off;
    off = `PIU_VEC_STEP * {{(`PIU_VEC_W-`PIU_IDX_W){1'b0}}, idx};
    return `PIU_VEC_BASE + off;
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and decoded strobes

  piu_state_t st_q; // Registered state
  piu_state_t st_d; // Next state
  piu_src_vec_t src_set; // Hardware set events this cycle
  piu_src_vec_t take_mask; // Flag cleared by a vector take
  piu_src_vec_t flags_pre; // Flags after clears, before sets
  piu_src_vec_t clr_mask; // Flags cleared this cycle
  piu_src_vec_t eligible; // Flags that may be vectored
  logic async_req_b; // Combined async port request, active low
  logic bus_go; // Access completes at this edge
  logic bus_req; // Access presented in its first cycle
  logic wr_ctrl; // Write to control register
  logic wr_enable; // Write to enable register
  logic wr_flags; // Write to flag register
  logic take; // Core accepts the offered vector
  logic [31:0] rd_word; // Read decode
  logic [31:0] flag_word; // Flag write merged
  logic [31:0] enable_word; // Enable write merged

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    st_d = st_q;
    // Supply monitor is asynchronous to us; two flops before any use
    st_d.lowsup_s1 = i_low_supply;
    st_d.lowsup_s2 = st_q.lowsup_s1;
    st_d.lowsup_prev = st_q.lowsup_s2;
    async_req_b = ~|i_events.async_port_status_bits;
    st_d.async_req_b_prev = async_req_b;
    // Set events, one per source
    src_set = '0;
    src_set[`PIU_SRC_CTM_P] = i_events.ctm_p_match;
    src_set[`PIU_SRC_CTM_A] = i_events.ctm_a_match;
    src_set[`PIU_SRC_PTM_P] = i_events.ptm_p_match;
    src_set[`PIU_SRC_PTM_A] = i_events.ptm_a_match;
    src_set[`PIU_SRC_WRDONE] = i_events.write_done;
    src_set[`PIU_SRC_LOWSUP] = st_q.lowsup_s2 & ~st_q.lowsup_prev;
    src_set[`PIU_SRC_TOUCH] = i_events.touch_ovf;
    src_set[`PIU_SRC_SERIAL] = |i_events.serial_events;
    src_set[`PIU_SRC_ASYNC] = st_q.async_req_b_prev & ~async_req_b;

    // Bus decode; the access takes effect when waitrequest is low
    bus_req = (i_read | i_write) & st_q.waitrequest;
    bus_go = (i_read | i_write) & ~st_q.waitrequest;
    wr_ctrl = bus_go & i_write & (i_address == `PIU_CTRL_OFS) & i_byteenable[0];
    wr_enable = bus_go & i_write & (i_address == `PIU_ENABLE_OFS);
    wr_flags = bus_go & i_write & (i_address == `PIU_FLAGS_OFS);
    flag_word = be_merge({{(32-`PIU_NUM_SRC){1'b0}}, st_q.flags}, i_writedata, i_byteenable);

    take = i_vec_take & st_q.vec.valid;
    take_mask = take ? src_mask(st_q.vec.index) : '0;

    // Enables steer which flags may vector; merged word kept whole, low bits used
    enable_word = be_merge({{(32-`PIU_NUM_SRC){1'b0}}, st_q.enable}, i_writedata, i_byteenable);
    if (wr_enable)
    begin
      st_d.enable = enable_word[`PIU_NUM_SRC-1:0];
    end

    if (i_return_from_irq_instr)
    begin
      st_d.global_irq_enable = 1'b1;
    end
    if (take)
    begin
      st_d.global_irq_enable = 1'b0;
    end
    // Software write has the last word
    if (wr_ctrl)
    begin
      st_d.global_irq_enable = i_writedata[`PIU_CTRL_GIE_BIT];
    end

    // Software may set or clear flags; setting one wakes, then its later events cannot wake
    flags_pre = wr_flags ? flag_word[`PIU_NUM_SRC-1:0] : st_q.flags;
    flags_pre = flags_pre & ~take_mask;
    clr_mask = st_q.flags & ~flags_pre;
    // sticky flags, set wins over clear
    st_d.flags = flags_pre | src_set;

    st_d.wake = |(st_d.flags & ~st_q.flags);

    eligible = st_d.flags & st_d.enable & {`PIU_NUM_SRC{st_d.global_irq_enable & ~i_stack_full}};
    st_d.vec.valid = |eligible;
    st_d.vec.index = first_set(eligible);
    st_d.vec.addr = vec_addr(st_d.vec.index);

    // Read decode; unmapped offsets read as zero
    rd_word = '0;
    unique case (i_address)
      `PIU_CTRL_OFS: rd_word[`PIU_CTRL_GIE_BIT] = st_q.global_irq_enable;
      `PIU_ENABLE_OFS: rd_word[`PIU_NUM_SRC-1:0] = st_q.enable;
      `PIU_FLAGS_OFS: rd_word[`PIU_NUM_SRC-1:0] = st_q.flags;
      `PIU_STATUS_OFS:
      begin
        rd_word[`PIU_STAT_VALID_BIT] = st_q.vec.valid;
        rd_word[`PIU_STAT_INDEX_LSB +: `PIU_IDX_W] = st_q.vec.index;
        rd_word[`PIU_STAT_ASYNC_LSB +: 6] = i_events.async_port_status_bits;
        rd_word[`PIU_STAT_LOWSUP_BIT] = st_q.lowsup_s2;
      end
      default: rd_word = '0;
    endcase
    // One wait cycle: data is captured in the first cycle, stands while waitrequest is low
    if (bus_req & i_read)
    begin
      st_d.readdata = rd_word;
    end
    st_d.waitrequest = ~bus_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q <= '0;
      st_q.global_irq_enable <= `PIU_RST_GIE;
      st_q.enable <= `PIU_RST_ENABLE;
      st_q.flags <= `PIU_RST_FLAGS;
      st_q.waitrequest <= `PIU_RST_WAIT;
      st_q.async_req_b_prev <= `PIU_RST_ASYNC_REQ_B;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign o_readdata = st_q.readdata;
  assign o_waitrequest = st_q.waitrequest;
  assign o_vec = st_q.vec;
  assign o_wake = st_q.wake;
  assign o_global_irq_enable = st_q.global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Helper copies of eligibility and of the taken flag at the register edge
  piu_src_vec_t elig_q;
  piu_src_vec_t taken_q; // Flag cleared by a take and not set again
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      elig_q <= '0;
      taken_q <= '0;
    end
    else
    begin
      elig_q <= eligible;
      taken_q <= take_mask & ~src_set;
    end
  end

  sequence s_bus_req;
    (i_read || i_write) && o_waitrequest;
  endsequence

  sequence s_bus_ack;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  sequence s_take;
    i_vec_take && o_vec.valid && !i_return_from_irq_instr && !wr_ctrl;
  endsequence

  bus_one_wait_a: assert property (s_bus_req |=> s_bus_ack)
    else $error("bus answer not after one wait cycle");

  take_clears_gie_a: assert property (s_take |=> !o_global_irq_enable)
    else $error("global enable not cleared on take");

  take_clears_flag_a: assert property (take && !wr_flags |=>
    ((st_q.flags & taken_q) == '0))
    else $error("taken flag still set");

  vec_gated_a: assert property (o_vec.valid |-> o_global_irq_enable &&
    st_q.flags[o_vec.index] && st_q.enable[o_vec.index])
    else $error("vector offered without its gates");

  stack_blocks_a: assert property (i_stack_full |=> !o_vec.valid)
    else $error("vector offered with stack full");

  return_from_irq_instr_sets_gie_a: assert property (i_return_from_irq_instr && !take && !wr_ctrl |=> o_global_irq_enable)
    else $error("return-from-irq did not set global enable");

  flag_sticky_a: assert property (((~st_q.flags & $past(st_q.flags)) & ~$past(clr_mask)) == '0)
    else $error("flag fell without a clear");

  event_latched_a: assert property (|src_set |=> ((st_q.flags & $past(src_set)) == $past(src_set)))
    else $error("event not latched in flag");

  rise_wakes_a: assert property (|(st_q.flags & ~$past(st_q.flags)) |-> o_wake)
    else $error("flag rose without wake");

  prio_order_a: assert property (o_vec.valid |-> elig_q[o_vec.index] &&
    ((elig_q & ~({`PIU_NUM_SRC{1'b1}} << o_vec.index)) == '0))
    else $error("vector not the highest priority");

  vec_addr_a: assert property (o_vec.valid |->
    (o_vec.addr == (`PIU_VEC_BASE + (`PIU_VEC_STEP * {8'h00, o_vec.index}))))
    else $error("vector address wrong");

  async_sets_flag_a: assert property ($fell(async_req_b) |=> st_q.flags[`PIU_SRC_ASYNC])
    else $error("async port request not latched");

  serial_sets_flag_a: assert property (|i_events.serial_events |=> st_q.flags[`PIU_SRC_SERIAL])
    else $error("serial event not latched");

  wrdone_sets_flag_a: assert property (i_events.write_done |=> st_q.flags[`PIU_SRC_WRDONE])
    else $error("write completion not latched");

  lowsup_sets_flag_a: assert property ($rose(st_q.lowsup_s2) |=> st_q.flags[`PIU_SRC_LOWSUP])
    else $error("low supply not latched");

  touch_sets_flag_a: assert property (i_events.touch_ovf |=> st_q.flags[`PIU_SRC_TOUCH])
    else $error("touch overflow not latched");

  timer_sets_flag_a: assert property (i_events.ptm_a_match |=> st_q.flags[`PIU_SRC_PTM_A])
    else $error("timer match not latched");

endmodule // piu_interrupt_unit

/* File: pkg/piu_consts.svh */
// Constants for the peripheral interrupt unit: offsets, fields, reset values, vectors
`ifndef PIU_CONSTS_SVH
`define PIU_CONSTS_SVH

// Number of interrupt sources and their fixed priority index (0 is highest)
`define PIU_NUM_SRC 9
`define PIU_IDX_W 4
`define PIU_SRC_CTM_P 4'h0
`define PIU_SRC_CTM_A 4'h1
`define PIU_SRC_PTM_P 4'h2
`define PIU_SRC_PTM_A 4'h3
`define PIU_SRC_WRDONE 4'h4
`define PIU_SRC_LOWSUP 4'h5
`define PIU_SRC_TOUCH 4'h6
`define PIU_SRC_SERIAL 4'h7
`define PIU_SRC_ASYNC 4'h8

// Register byte offsets on the Avalon-MM slave
`define PIU_ADDR_W 4
`define PIU_CTRL_OFS 4'h0
`define PIU_ENABLE_OFS 4'h4
`define PIU_FLAGS_OFS 4'h8
`define PIU_STATUS_OFS 4'hc

// Field positions
`define PIU_CTRL_GIE_BIT 0
`define PIU_STAT_VALID_BIT 0
`define PIU_STAT_INDEX_LSB 4
`define PIU_STAT_ASYNC_LSB 8
`define PIU_STAT_LOWSUP_BIT 16

// Reset values
`define PIU_RST_GIE 1'b0
`define PIU_RST_ENABLE 9'h000
`define PIU_RST_FLAGS 9'h000
`define PIU_RST_WAIT 1'b1
`define PIU_RST_ASYNC_REQ_B 1'b1

// Vector table: each source owns a distinct address
`define PIU_VEC_W 12
`define PIU_VEC_BASE 12'h004
`define PIU_VEC_STEP 12'h004

`endif

/* File: pkg/piu_pkg.sv */
// Types shared by the peripheral interrupt unit
`include "piu_consts.svh"

package piu_pkg;

  // One bit per interrupt source
  typedef logic [`PIU_NUM_SRC-1:0] piu_src_vec_t;

  // Event inputs from the on-chip peripherals, all on the system clock
  typedef struct packed {
    logic ctm_p_match;
    logic ctm_a_match;
    logic ptm_p_match;
    logic ptm_a_match;
    logic write_done;
    logic touch_ovf;
    logic [3:0] serial_events;
    logic [5:0] async_port_status_bits;
  } piu_events_t;

  // Vector request towards the core sequencer
  typedef struct packed {
    logic valid;
    logic [`PIU_IDX_W-1:0] index;
    logic [`PIU_VEC_W-1:0] addr;
  } piu_vec_t;

  // Whole state of the unit
  typedef struct packed {
    logic global_irq_enable;
    piu_src_vec_t enable;
    piu_src_vec_t flags;
    piu_vec_t vec;
    logic wake;
    logic waitrequest;
    logic [31:0] readdata;
    logic lowsup_s1;
    logic lowsup_s2;
    logic lowsup_prev;
    logic async_req_b_prev;
  } piu_state_t;

endpackage

/* File: verif/peripheral_interrupt_unit_tb_top.sv */
// Bench for the peripheral interrupt unit: bus tasks and service scenarios
`timescale 1ns/10ps
`include "piu_consts.svh"

module peripheral_interrupt_unit_tb_top
  import piu_pkg::*;
;
  logic i_clk, i_rst_b, rd, wr, stk, ret_p, low, wq, wake, gie, take;
  logic [3:0] adr, dly;
  logic [31:0] wdat, rdat, rq;
  logic [7:0] tcnt, n;
  logic [11:0] vaddr;
  logic [3:0] vidx;
  piu_events_t ev;
  piu_vec_t vec;
  int n_fail, n_tests, cyc, wakes, w, s, k;

  piu_interrupt_unit u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_writedata(wdat), .i_byteenable(4'hf), .o_readdata(rq), .o_waitrequest(wq),
    .i_events(ev), .i_low_supply(low), .i_stack_full(stk), .i_vec_take(take), .i_return_from_irq_instr(ret_p),
    .o_vec(vec), .o_wake(wake), .o_global_irq_enable(gie));
  piu_core_model u_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_vec(vec), .i_delay(dly),
    .o_take(take), .o_taken_cnt(tcnt), .o_last_addr(vaddr), .o_last_index(vidx));

  ////////////////////////////////////////////////////////////////
  // Clock, hang guard and wake pulse counter
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Avalon cycle: hold everything until waitrequest is sampled low
  task automatic bus(input logic w_, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w_;
    wr <= w_;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk); while (wq !== 1'b0);
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // Raise one source; serial and async take a condition code k
  task automatic fire(input int src, input int c);
    @(posedge i_clk);
    case (src)
      0: ev.ctm_p_match <= 1'b1;
      1: ev.ctm_a_match <= 1'b1;
      2: ev.ptm_p_match <= 1'b1;
      3: ev.ptm_a_match <= 1'b1;
      4: ev.write_done <= 1'b1;
      5: low <= 1'b1;
      6: ev.touch_ovf <= 1'b1;
      7: ev.serial_events <= 4'h1 << c;
      default: ev.async_port_status_bits <= 6'h01 << c;
    endcase
    @(posedge i_clk);
    ev[15:6] <= 10'h000;
  endtask
  task automatic wait_take(input logic [7:0] old);
    for (int j = 0; j < 50 && tcnt === old; j++) @(posedge i_clk);
    chk("take count", old + 8'h01, tcnt);
  endtask
  task automatic ret();
    @(posedge i_clk);
    ret_p <= 1'b1;
    @(posedge i_clk);
    ret_p <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {rd, wr, stk, ret_p, low} = 5'h00;
    adr = 4'h0;
    dly = 4'h0;
    wdat = 32'h0;
    ev = '0;
    i_rst_b = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("vec at reset", 32'h0, vec);
    rdchk(`PIU_CTRL_OFS, 32'h0, "ctrl reset");
    rdchk(`PIU_ENABLE_OFS, 32'h0, "enable reset");
    rdchk(`PIU_FLAGS_OFS, 32'h0, "flags reset");
    bus(1'b1, 4'h2, 32'hffffffff);
    rdchk(4'h2, 32'h0, "unmapped");
    $display("test reset and map done");
    // Every source, every serial and async condition, prompt core
    for (int i = 0; i < 17; i++)
    begin
      s = (i < 9) ? i : (i < 12) ? 7 : 8;
      k = (i < 9) ? 0 : (i < 12) ? i - 8 : i - 11;
      bus(1'b1, `PIU_ENABLE_OFS, 32'h1 << s);
      bus(1'b1, `PIU_CTRL_OFS, 32'h1);
      n = tcnt;
      fire(s, k);
      wait_take(n);
      chk("vector", 32'h004 + 4 * s, vaddr);
      rdchk(`PIU_CTRL_OFS, 32'h0, "gie after entry");
      chk("gie pin", 32'h0, gie);
      rdchk(`PIU_FLAGS_OFS, 32'h0, "flag after entry");
      bus(1'b0, `PIU_STATUS_OFS, 32'h0);
      if (s == 8) chk("port status", 32'h100 << k, rdat & 32'h3f00);
      chk("status", (s == 5) ? 32'h10000 : 32'h0, rdat & 32'h10001);
      @(posedge i_clk);
      low <= 1'b0;
      ev.async_port_status_bits <= 6'h00;
      ret();
      rdchk(`PIU_CTRL_OFS, 32'h1, "gie after return");
      chk("gie pin return", 32'h1, gie);
    end
    $display("test sources done");
    // Full stack holds the offer back
    stk <= 1'b1;
    n = tcnt;
    bus(1'b1, `PIU_ENABLE_OFS, 32'h1);
    fire(0, 0);
    repeat (6) @(posedge i_clk);
    chk("offer while full", 32'h0, vec.valid);
    chk("no take while full", n, tcnt);
    stk <= 1'b0;
    wait_take(n);
    $display("test stack full done");
    // Latched while disabled, fixed priority, slow core, plain return
    bus(1'b1, `PIU_ENABLE_OFS, 32'h1ff);
    fire(3, 0);
    fire(1, 0);
    rdchk(`PIU_FLAGS_OFS, 32'h00a, "latched flags");
    dly <= 4'h5;
    n = tcnt;
    bus(1'b1, `PIU_CTRL_OFS, 32'h1);
    wait_take(n);
    chk("first index", 32'h1, vidx);
    repeat (5) @(posedge i_clk);
    rdchk(`PIU_CTRL_OFS, 32'h0, "gie plain return");
    rdchk(`PIU_FLAGS_OFS, 32'h008, "pending flag");
    n = tcnt;
    ret();
    wait_take(n);
    chk("second index", 32'h3, vidx);
    $display("test priority done");
    // Wake ignores enables; a preset flag cannot wake again
    bus(1'b1, `PIU_ENABLE_OFS, 32'h0);
    w = wakes;
    fire(6, 0);
    repeat (2) @(posedge i_clk);
    chk("wake", w + 1, wakes);
    rdchk(`PIU_FLAGS_OFS, 32'h040, "disabled flag kept");
    bus(1'b1, `PIU_FLAGS_OFS, 32'h0c0);
    // A software-set flag rises too; let its own wake pulse pass before counting
    repeat (2) @(posedge i_clk);
    w = wakes;
    fire(7, 1);
    repeat (2) @(posedge i_clk);
    chk("no wake", w, wakes);
    rdchk(`PIU_FLAGS_OFS, 32'h0c0, "flags kept");
    bus(1'b1, `PIU_FLAGS_OFS, 32'h0);
    rdchk(`PIU_FLAGS_OFS, 32'h0, "software clear");
    $display("test wake done");
    conclude();
  end
endmodule // peripheral_interrupt_unit_tb_top

/* File: verif/piu_core_model.sv */
// Core sequencer model: accepts offered vectors after a set delay and logs them
`timescale 1ns/10ps
`include "piu_consts.svh"

module piu_core_model
  import piu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire piu_vec_t i_vec,
  input wire logic [3:0] i_delay,
  output logic o_take,
  output logic [7:0] o_taken_cnt,
  output logic [`PIU_VEC_W-1:0] o_last_addr,
  output logic [`PIU_IDX_W-1:0] o_last_index
);
  // Cycles the current offer has been waiting
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////
  // Only the return address is pushed, so a handler saves its own registers
  // single level entry
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_take <= 1'b0;
      wait_q <= 4'h0;
      o_taken_cnt <= 8'h00;
      o_last_addr <= '0;
      o_last_index <= '0;
    end
    else
    begin
      // Log only a take that met a live offer
      if (o_take && i_vec.valid)
      begin
        o_taken_cnt <= o_taken_cnt + 8'h01;
        o_last_addr <= i_vec.addr;
        o_last_index <= i_vec.index;
      end
      // One-cycle take after the chosen delay; a slow core keeps the offer waiting
      o_take <= i_vec.valid && !o_take && (wait_q == i_delay);
      wait_q <= (i_vec.valid && !o_take) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // piu_core_model
